// file: rtl/smi_params.svh
// Register offsets, field positions, masks and reset values of the
// system-management interrupt aggregator.
// Assumes it is included by bare name from the package and the design files.
`ifndef SMI_PARAMS_SVH
`define SMI_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_STS1     8'h14
`define OFS_STS2     8'h15
`define OFS_STS3     8'h16
`define OFS_STS4     8'h17
`define OFS_EN1      8'h18
`define OFS_EN2      8'h19
`define OFS_EN3      8'h1A
`define OFS_EN4      8'h1B
`define OFS_MSC      8'h1C

// ----------------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------------
`define RST_REG      8'h00
`define EN1_MASK     8'h9F
`define EN2_MASK     8'hF7
`define EN2_SRC_MASK 8'h17
`define EN3_MASK     8'hFE
`define MSC_MASK     8'h3F
`define MSC_RD_MASK  8'h33

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_BATT     0
`define BIT_IR       2
`define BIT_CLICK    4
`define BIT_TO_WAKE  5
`define BIT_TO_SER   6
`define BIT_TO_PIN   7
`define SRC_COUNT    25

`endif

// file: rtl/smi_pkg.sv
// Types shared by the interrupt aggregator files.
// Assumes smi_params.svh is on the include path.
`include "smi_params.svh"

package smi_pkg;
  typedef logic [7:0]            reg8_t;
  typedef logic [7:0]            addr_t;
  typedef logic [`SRC_COUNT-1:0] src_vec_t;
endpackage

// file: rtl/pin_edge_sync.sv
// Two-flop synchroniser with level, rising-edge and either-edge outputs.
// Assumes asynchronous inputs and one clock; the first flop feeds only the second.
`timescale 1ns/100ps

module pin_edge_sync (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Raw pins and conditioned views.
  input  wire smi_pkg::src_vec_t din,
  output smi_pkg::src_vec_t      level,
  output smi_pkg::src_vec_t      rise,
  output smi_pkg::src_vec_t      toggle
);
  import smi_pkg::*;

  src_vec_t meta_ff;
  src_vec_t sync_ff;
  src_vec_t prev_ff;

  // Two flops bring the pins into the clock domain; a third holds history.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edge terms look only at the synchronised and history flops.
  assign level  = sync_ff;
  assign rise   = sync_ff & ~prev_ff;
  assign toggle = sync_ff ^ prev_ff;
endmodule

// file: rtl/sysmgmt_interrupt_aggregator.sv
// System-management interrupt aggregator: status latches, enables, routing.
// Assumes a single 100 MHz clock, synchronous low reset, asynchronous source pins.
//
// How it works
// RULE_01: Status 3 bits 1-7 latch gpio21..gpio60 events; bit0 reserved; write one clears.
// RULE_02: Status 4 latches uart3,uart4,gpio32,gpio33,uart5,gpio42,uart6,gpio61; write one clears.
// RULE_03: Enable 1 gates battery, parallel, uart2, uart1, floppy, watchdog; bits 5,6 reserved.
// RULE_04: Enable 2 gates mouse, keyboard, infrared, click wake; bit 3 reserved.
// RULE_05: Enable 2 bit 5 forwards the group request to the wake logic.
// RULE_06: Enable 2 bit 6 puts the group request into the serial IRQ slot.
// RULE_07: Enable 2 bit 7 drives the group request onto the low-active pin.
// RULE_08: Enable 3 mirrors status 3, bits 1-7, bit 0 reserved.
// RULE_09: Enable 4 mirrors status 4 bit for bit.
// RULE_10: A source reaches the group request only while its enable bit is one.
// RULE_11: Edge status latches either edge of gpio21, gpio22, gpio60, gpio61.
// RULE_12: Writing one clears edge status bits 5:0; zero leaves them.
// RULE_13: Edge status bits 7:6 always read zero.
// RULE_14: Infrared status sets on any receive-pin transition; reading status 2 clears it.
// RULE_15: Battery-low bit clears on write one; other status 1 bits follow sources.
// RULE_16: Group request is OR of status AND enable over status registers 1-4; edge status is not included.
// RULE_17: Status bits latch regardless of enable settings.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "smi_params.svh"

module sysmgmt_interrupt_aggregator (
  // Clock and reset.
  input  wire logic          SYS_CLK,
  input  wire logic          RSTN,
  // Register port.
  input  wire smi_pkg::addr_t ADDR,
  input  wire smi_pkg::reg8_t WR_DATA,
  input  wire logic          WR_STB,
  input  wire logic          RD_STB,
  output smi_pkg::reg8_t     RD_DATA,
  // Peripheral interrupt sources, active high.
  input  wire logic          BATT_LOW,
  input  wire logic          PAR_IRQ,
  input  wire logic          UART1_IRQ,
  input  wire logic          UART2_IRQ,
  input  wire logic          FLOPPY_IRQ,
  input  wire logic          WDOG_IRQ,
  input  wire logic          MOUSE_IRQ,
  input  wire logic          KBD_IRQ,
  input  wire logic          IR_RX,
  input  wire logic          MOUSE_CLICK_WAKE,
  input  wire logic          UART3_IRQ,
  input  wire logic          UART4_IRQ,
  input  wire logic          UART5_IRQ,
  input  wire logic          UART6_IRQ,
  // General-purpose event pins.
  input  wire logic          GPIO21,
  input  wire logic          GPIO22,
  input  wire logic          GPIO54,
  input  wire logic          GPIO55,
  input  wire logic          GPIO56,
  input  wire logic          GPIO57,
  input  wire logic          GPIO60,
  input  wire logic          GPIO32,
  input  wire logic          GPIO33,
  input  wire logic          GPIO42,
  input  wire logic          GPIO61,
  // Group request routes.
  output logic               GROUP_INTERRUPT_PIN_N,
  output logic               SERIRQ_GROUP_REQ,
  output logic               WAKE_GROUP_REQ
);
  import smi_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Write-one-to-clear update in which a new event wins over the clear.
  function automatic reg8_t w1c(input reg8_t cur, input reg8_t set, input reg8_t clr);
    w1c = (cur & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------------
  // Source conditioning
  // ----------------------------------------------------------------------
  src_vec_t raw;
  src_vec_t lvl;
  src_vec_t rise;
  src_vec_t tgl;

  // Sources packed in a fixed order; bit 0 is the battery input.
  assign raw = {GPIO61, GPIO42, GPIO33, GPIO32, GPIO60, GPIO57, GPIO56, GPIO55, GPIO54,
                GPIO22, GPIO21, UART6_IRQ, UART5_IRQ, UART4_IRQ, UART3_IRQ,
                MOUSE_CLICK_WAKE, IR_RX, KBD_IRQ, MOUSE_IRQ, WDOG_IRQ, FLOPPY_IRQ,
                UART1_IRQ, UART2_IRQ, PAR_IRQ, BATT_LOW};

  pin_edge_sync u_sync (
    .clk    (SYS_CLK),
    .rst_n  (RSTN),
    .din    (raw),
    .level  (lvl),
    .rise   (rise),
    .toggle (tgl)
  );

  // Event vectors laid out in register bit order.
  reg8_t sts1_live;
  reg8_t sts3_set;
  reg8_t sts4_set;
  reg8_t msc_set;
  logic  batt_set;
  logic  ir_set;
  logic  click_set;

  assign batt_set  = rise[0];
  assign sts1_live = {lvl[5], 2'b00, lvl[4], lvl[3], lvl[2], lvl[1], 1'b0};
  assign ir_set    = tgl[8]; // RULE_14
  assign click_set = rise[9];
  assign sts3_set  = {rise[20:14], 1'b0}; // RULE_01
  assign sts4_set  = {rise[24], lvl[13], rise[23], lvl[12], rise[22], rise[21], lvl[11], lvl[10]}; // RULE_02
  assign msc_set   = {2'b00, tgl[24], tgl[20], 2'b00, tgl[15], tgl[14]}; // RULE_11

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic wr_sts1, wr_sts2, wr_sts3, wr_sts4, wr_msc;
  logic wr_en1, wr_en2, wr_en3, wr_en4;
  logic rd_sts2;

  assign wr_sts1 = WR_STB && (ADDR == `OFS_STS1);
  assign wr_sts2 = WR_STB && (ADDR == `OFS_STS2);
  assign wr_sts3 = WR_STB && (ADDR == `OFS_STS3);
  assign wr_sts4 = WR_STB && (ADDR == `OFS_STS4);
  assign wr_en1  = WR_STB && (ADDR == `OFS_EN1);
  assign wr_en2  = WR_STB && (ADDR == `OFS_EN2);
  assign wr_en3  = WR_STB && (ADDR == `OFS_EN3);
  assign wr_en4  = WR_STB && (ADDR == `OFS_EN4);
  assign wr_msc  = WR_STB && (ADDR == `OFS_MSC);
  assign rd_sts2 = RD_STB && (ADDR == `OFS_STS2);

  // ----------------------------------------------------------------------
  // Status latches
  // ----------------------------------------------------------------------
  logic  batt_ff;
  logic  ir_ff;
  logic  click_ff;
  reg8_t sts3_ff;
  reg8_t sts4_ff;
  reg8_t msc_ff;

  // Battery-low latch clears on a written one; a new edge wins.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      batt_ff <= 1'b0;
    end else begin
      batt_ff <= batt_set | (batt_ff & ~(wr_sts1 & WR_DATA[`BIT_BATT])); // RULE_15
    end
  end

  // Infrared activity clears on a read of status 2; a transition wins.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ir_ff <= 1'b0;
    end else begin
      ir_ff <= ir_set | (ir_ff & ~rd_sts2); // RULE_14
    end
  end

  // Click-wake latch clears on a written one.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      click_ff <= 1'b0;
    end else begin
      click_ff <= click_set | (click_ff & ~(wr_sts2 & WR_DATA[`BIT_CLICK]));
    end
  end

  // Pin event latches; they set whatever the enables say.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      sts3_ff <= `RST_REG;
      sts4_ff <= `RST_REG;
      msc_ff  <= `RST_REG;
    end else begin
      sts3_ff <= w1c(sts3_ff, sts3_set, wr_sts3 ? WR_DATA : 8'h00) & 8'hFE; // RULE_01 RULE_17
      sts4_ff <= w1c(sts4_ff, sts4_set, wr_sts4 ? WR_DATA : 8'h00); // RULE_02 RULE_17
      msc_ff  <= w1c(msc_ff, msc_set, wr_msc ? (WR_DATA & `MSC_MASK) : 8'h00); // RULE_12
    end
  end

  // ----------------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------------
  reg8_t en1_ff;
  reg8_t en2_ff;
  reg8_t en3_ff;
  reg8_t en4_ff;

  // Reserved enable bits are not stored and read as zero.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      en1_ff <= `RST_REG;
      en2_ff <= `RST_REG;
      en3_ff <= `RST_REG;
      en4_ff <= `RST_REG;
    end else begin
      if (wr_en1) en1_ff <= WR_DATA & `EN1_MASK; // RULE_03
      if (wr_en2) en2_ff <= WR_DATA & `EN2_MASK; // RULE_04
      if (wr_en3) en3_ff <= WR_DATA & `EN3_MASK; // RULE_08
      if (wr_en4) en4_ff <= WR_DATA; // RULE_09
    end
  end

  // ----------------------------------------------------------------------
  // Readable status views and group request
  // ----------------------------------------------------------------------
  reg8_t sts1_view;
  reg8_t sts2_view;
  logic  group_ff;
  logic  nxt_group;

  assign sts1_view = sts1_live | {7'h00, batt_ff};
  assign sts2_view = {3'b000, click_ff, 1'b0, ir_ff, lvl[7], lvl[6]};

  // Each status bit counts only under its enable bit.
  assign nxt_group = |(sts1_view & en1_ff)                     // RULE_10 RULE_16
                   | |(sts2_view & en2_ff & `EN2_SRC_MASK)
                   | |(sts3_ff & en3_ff)
                   | |(sts4_ff & en4_ff);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      group_ff <= 1'b0;
    end else begin
      group_ff <= nxt_group; // RULE_16
    end
  end

  // Route the group request to pin, serial IRQ slot and wake logic.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      GROUP_INTERRUPT_PIN_N <= 1'b1;
      SERIRQ_GROUP_REQ      <= 1'b0;
      WAKE_GROUP_REQ        <= 1'b0;
    end else begin
      GROUP_INTERRUPT_PIN_N <= ~(group_ff & en2_ff[`BIT_TO_PIN]); // RULE_07
      SERIRQ_GROUP_REQ      <= group_ff & en2_ff[`BIT_TO_SER]; // RULE_06
      WAKE_GROUP_REQ        <= group_ff & en2_ff[`BIT_TO_WAKE]; // RULE_05
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  reg8_t nxt_rd;

  // Unmapped offsets read zero.
  always_comb begin
    nxt_rd = 8'h00;
    case (ADDR)
      `OFS_STS1: nxt_rd = sts1_view;
      `OFS_STS2: nxt_rd = sts2_view;
      `OFS_STS3: nxt_rd = sts3_ff;
      `OFS_STS4: nxt_rd = sts4_ff;
      `OFS_EN1:  nxt_rd = en1_ff;
      `OFS_EN2:  nxt_rd = en2_ff;
      `OFS_EN3:  nxt_rd = en3_ff;
      `OFS_EN4:  nxt_rd = en4_ff;
      `OFS_MSC:  nxt_rd = msc_ff & `MSC_RD_MASK; // RULE_13
      default:   nxt_rd = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= RD_STB ? nxt_rd : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_group_up;
    group_ff && en2_ff[`BIT_TO_PIN];
  endsequence

  sequence s_status_write(addr_t a);
    WR_STB && ADDR == a;
  endsequence

  chk_pin_follows_group: assert property (s_group_up |=> !GROUP_INTERRUPT_PIN_N) // RULE_07
    else $error("group pin not driven low");
  chk_pin_idle_disabled: assert property (!en2_ff[`BIT_TO_PIN] |=> GROUP_INTERRUPT_PIN_N) // RULE_07
    else $error("group pin active while disabled");
  chk_serirq_route: assert property (SERIRQ_GROUP_REQ == $past(group_ff && en2_ff[`BIT_TO_SER])) // RULE_06
    else $error("serial irq route mismatch");
  chk_wake_route: assert property (WAKE_GROUP_REQ == $past(group_ff && en2_ff[`BIT_TO_WAKE])) // RULE_05
    else $error("wake route mismatch");
  chk_masked_no_group: assert property (((en1_ff | en3_ff | en4_ff) == 8'h00) && // RULE_10
                                        ((en2_ff & `EN2_SRC_MASK) == 8'h00) |=> !group_ff)
    else $error("group set with no enabled source");
  chk_sts3_w1c_clear: assert property (s_status_write(`OFS_STS3) && sts3_set == 8'h00
                                      |=> (sts3_ff & $past(WR_DATA)) == 8'h00) // RULE_01
    else $error("status 3 bit not cleared");
  chk_sts4_set_wins: assert property ((sts4_set != 8'h00) |=> (sts4_ff & $past(sts4_set)) == $past(sts4_set)) // RULE_02
    else $error("status 4 event lost");
  chk_msc_upper_zero: assert property (RD_STB && ADDR == `OFS_MSC |=> RD_DATA[7:6] == 2'b00) // RULE_13
    else $error("edge status upper bits not zero");
  chk_ir_read_clear: assert property (rd_sts2 && !ir_set |=> !ir_ff) // RULE_14
    else $error("infrared bit not cleared by read");
  chk_batt_w1c: assert property (s_status_write(`OFS_STS1) && WR_DATA[0] && !batt_set |=> !batt_ff) // RULE_15
    else $error("battery bit not cleared");
  chk_group_latency: assert property (nxt_group |=> group_ff ##1 (SERIRQ_GROUP_REQ == en2_ff[`BIT_TO_SER] || $changed(en2_ff))) // RULE_16
    else $error("group request latency wrong");
endmodule

// file: verification/chipset_model.sv
// Host-side receiver of the group request on its three routes.
// Assumes the device drives registered levels on the same clock.
`timescale 1ns/100ps

module chipset_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Group request routes from the device.
  input  wire logic       pin_n,
  input  wire logic       serirq,
  input  wire logic       wake,
  // Requests seen: wake, serial slot, dedicated pin.
  output logic      [2:0] seen
);
  logic [2:0] seen_ff;

  // ----------------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------------
  // Samples every route each cycle; the dedicated pin is active when low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_ff <= 3'h0;
    end else begin
      seen_ff <= {wake, serirq, ~pin_n};
    end
  end

  // Presents the captured requests to the bench.
  assign seen = seen_ff;
endmodule

// file: verification/sysmgmt_interrupt_aggregator_test.sv
// Self-checking bench for the interrupt aggregator, with a host receiver model.
// Assumes the design, its package and the receiver model are compiled first.
`timescale 1ns/100ps

module sysmgmt_interrupt_aggregator_test;
  import smi_pkg::*;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  addr_t       addr = 8'h00;
  reg8_t       wdata = 8'h00;
  logic        wstb = 1'b0;
  logic        rstb = 1'b0;
  reg8_t       rdata;
  logic [13:0] s = 14'h0000;
  logic [10:0] gp = 11'h000;
  logic        pin_n;
  logic        serirq;
  logic        wake;
  logic [2:0]  seen;
  int          num_errors = 0;
  int          compares = 0;
  int          seed = 97498;
  reg8_t       e1;
  reg8_t       e2;
  logic        g;
  int          gbit[11] = '{1, 2, 3, 4, 5, 6, 7, 2, 3, 5, 7};
  int          ebit[11] = '{0, 1, -1, -1, -1, -1, 4, -1, -1, -1, 5};

  // ----------------------------------------------------------------------
  // Design, receiver model and clock
  // ----------------------------------------------------------------------
  sysmgmt_interrupt_aggregator dut_u (
    .SYS_CLK(clk), .RSTN(rstn), .ADDR(addr), .WR_DATA(wdata), .WR_STB(wstb),
    .RD_STB(rstb), .RD_DATA(rdata), .BATT_LOW(s[0]), .PAR_IRQ(s[1]),
    .UART1_IRQ(s[2]), .UART2_IRQ(s[3]), .FLOPPY_IRQ(s[4]), .WDOG_IRQ(s[5]),
    .MOUSE_IRQ(s[6]), .KBD_IRQ(s[7]), .IR_RX(s[8]), .MOUSE_CLICK_WAKE(s[9]),
    .UART3_IRQ(s[10]), .UART4_IRQ(s[11]), .UART5_IRQ(s[12]), .UART6_IRQ(s[13]),
    .GPIO21(gp[0]), .GPIO22(gp[1]), .GPIO54(gp[2]), .GPIO55(gp[3]),
    .GPIO56(gp[4]), .GPIO57(gp[5]), .GPIO60(gp[6]), .GPIO32(gp[7]),
    .GPIO33(gp[8]), .GPIO42(gp[9]), .GPIO61(gp[10]),
    .GROUP_INTERRUPT_PIN_N(pin_n), .SERIRQ_GROUP_REQ(serirq), .WAKE_GROUP_REQ(wake));

  chipset_model host_u (.clk(clk), .rst_n(rstn), .pin_n(pin_n), .serirq(serirq),
    .wake(wake), .seen(seen));

  // Toggles the 100 MHz clock every half period.
  always #5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic chk(reg8_t got, reg8_t exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Lets a fixed number of clock edges pass.
  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle register write.
  task automatic wr(addr_t a, reg8_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask

  // One-cycle register read; data is checked in the cycle after the strobe.
  task automatic rd(addr_t a, reg8_t exp);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Expected group request from the level sources and two enable registers.
  function automatic logic grp(logic [13:0] v, reg8_t a, reg8_t b);
    return |({v[5], 2'b00, v[4], v[2], v[3], v[1], 1'b0} & a) | |({v[7], v[6]} & b[1:0]);
  endfunction

  // Raises and lowers one event pin, checking status, edge status and routing.
  task automatic gp_event(int i);
    addr_t sa;
    reg8_t sb;
    reg8_t mb;
    sa = (i < 7) ? 8'h16 : 8'h17;
    sb = 8'h01 << gbit[i];
    mb = (ebit[i] < 0) ? 8'h00 : 8'h01 << ebit[i];
    wr(sa + 8'h04, sb);
    wr(8'h19, 8'h80);
    @(posedge clk);
    gp[i] <= 1'b1;
    idle(6);
    rd(sa, sb);
    chk({5'h00, seen}, 8'h01);
    rd(8'h1C, mb);
    wr(8'h1C, 8'h00);
    rd(8'h1C, mb);
    wr(sa, sb);
    wr(8'h1C, mb);
    gp[i] <= 1'b0;
    idle(6);
    chk({5'h00, seen}, 8'h00);
    rd(sa, 8'h00);
    rd(8'h1C, mb);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00);
    wr(sa + 8'h04, 8'h00);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Resets, then runs reset, routing, event and clear scenarios.
  initial begin
    idle(6);
    rstn <= 1'b1;
    for (int a = 8'h14; a <= 8'h1C; a++) begin
      rd(addr_t'(a), 8'h00);
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    for (int k = 0; k < 16; k++) begin
      e1 = reg8_t'($random(seed));
      e2 = (k == 0) ? 8'hE3 : reg8_t'($random(seed));
      @(posedge clk);
      s[7:1] <= (k == 0) ? 7'h7F : 7'($random(seed));
      wr(8'h18, e1);
      wr(8'h19, e2);
      idle(6);
      rd(8'h18, e1 & 8'h9F);
      rd(8'h19, e2 & 8'hF7);
      rd(8'h14, {s[5], 2'b00, s[4], s[2], s[3], s[1], 1'b0});
      g = grp(s, e1, e2);
      chk({5'h00, seen}, {5'h00, e2[5] & g, e2[6] & g, e2[7] & g});
    end
    @(posedge clk);
    s <= 14'h0000;
    wr(8'h18, 8'h00);
    for (int k = 0; k < 11; k++) begin
      gp_event(k);
    end
    @(posedge clk);
    s[13:10] <= 4'hF;
    idle(6);
    rd(8'h17, 8'h53);
    chk({5'h00, seen}, 8'h00);
    wr(8'h1B, 8'h10);
    idle(5);
    chk({5'h00, seen}, 8'h01);
    s[13:10] <= 4'h0;
    idle(3);
    wr(8'h17, 8'hFF);
    idle(5);
    chk({5'h00, seen}, 8'h00);
    rd(8'h17, 8'h00);
    wr(8'h1B, 8'h00);
    s[8] <= 1'b1;
    idle(6);
    rd(8'h15, 8'h04);
    rd(8'h15, 8'h00);
    @(posedge clk);
    s[9] <= 1'b1;
    wr(8'h19, 8'h90);
    idle(6);
    rd(8'h15, 8'h10);
    chk({5'h00, seen}, 8'h01);
    wr(8'h15, 8'h10);
    idle(5);
    chk({5'h00, seen}, 8'h00);
    s[0] <= 1'b1;
    idle(6);
    s[0] <= 1'b0;
    rd(8'h14, 8'h01);
    wr(8'h14, 8'h01);
    rd(8'h14, 8'h00);
    results();
  end

  // Cuts a hung run short and reports it as a failure.
  initial begin
    #900000;
    num_errors++;
    results();
  end
endmodule
